/* rtl/sdc_ctrl.sv */
`timescale 1ns/1ps
// Overview of operation
// - decimation_factor_reg sets the sinc filter decimation, hence output rate
// - chop off: decimation values 3 to 255 accepted
// - chop on: values under 13 act as 13
// - decimation_factor_reg resets to 8'h45
// - chop on: each extra decimation step adds 0.732 ms to conversion
// - chop on: output is mean of last two raws; settles after two periods
// - chop on: async input step fully shown from third result
// - burnout current only while input buffering enabled
// - per-converter select between bandgap and external reference
// - floating or low external reference sets no_ext_reference_flag
// - results clamped while reference missing
// - bad reference in calibration blocks cal write and sets fault flag
// - detection watches first reference pin pair only
// - chop off throughput spans 16.06 Hz to 1.365 kHz
// - chop on throughput spans 5.4 Hz to 105 Hz
// - aux polarity bit: 0 bipolar, 1 unipolar
// - sixty hertz notch bit 6 valid only with decimation 68 or more
module sdc_ctrl #(
	parameter int unsigned DIV = sdc_pkg::MOD_DIV
) (
	input  wire logic                 clk,
	input  wire logic                 rst_b,
	input  wire logic                 sf_we,
	input  wire logic [7:0]           sf_wdata,
	input  sdc_pkg::sdc_cfg_t         cfg,
	input  wire logic [7:0]           mode_reg,
	input  wire logic                 ref_pos_ok,
	input  wire logic                 ref_neg_ok,
	input  wire logic                 ref2_ok,
	input  wire logic                 cal_active_main,
	input  wire logic                 cal_active_aux,
	input  wire logic                 cal_done,
	input  wire logic [23:0]          raw_data,
	input  wire logic                 stat_clr,
	output logic [7:0]                decimation_factor_reg,
	output logic [7:0]                active_sf,
	output logic [23:0]               result,
	output logic                      result_valid,
	output logic                      result_settled,
	output logic                      burnout_en,
	output logic                      use_ext_ref_main,
	output logic                      use_ext_ref_aux,
	output logic                      aux_unipolar,
	output logic                      notch_active,
	output logic                      cal_write_main,
	output logic                      cal_write_aux,
	output sdc_pkg::sdc_stat_t        converter_status_reg
);
	logic [1:0]  ref_sync;
	logic        ref2_seen;
	logic        conv_done;
	logic [23:0] prev_raw;
	logic [1:0]  settle_cnt;
	logic [7:0]  eff_sf;
	logic        chop_q;
	logic        mode_q;

	sdc_sync2 #(.W(2)) u_sync (
		.clk   (clk),
		.rst_b (rst_b),
		.din   ({ref_pos_ok, ref_neg_ok}),
		.dout  (ref_sync)
	);

	// second pair only sampled for completeness; it never reaches the detector
	sdc_sync2 #(.W(1)) u_sync2 (
		.clk   (clk),
		.rst_b (rst_b),
		.din   (ref2_ok),
		.dout  (ref2_seen)
	);

	// either pin floating or low means missing
	wire ref_missing = ~(ref_sync[1] & ref_sync[0]);

	wire [7:0] sf_floor = cfg.chop_en ? sdc_pkg::SF_MIN_CHOP
	                                  : sdc_pkg::SF_MIN_NOCHOP;
	wire [7:0] clamped_sf = (decimation_factor_reg < sf_floor) ? sf_floor
	                                                           : decimation_factor_reg;

	sdc_rate_div #(.DIV(DIV)) u_rate (
		.clk       (clk),
		.rst_b     (rst_b),
		.eff_sf    (eff_sf),
		.chop_en   (chop_q),
		.conv_done (conv_done)
	);

	wire [24:0] pair_sum = {1'b0, raw_data} + {1'b0, prev_raw};
	wire [23:0] avg      = pair_sum[24:1];
	wire [23:0] picked   = chop_q ? avg : raw_data;
	wire        reprog   = sf_we | (cfg.chop_en != chop_q)
	                       | (mode_reg[sdc_pkg::NOTCH_BIT] != mode_q);
	wire        set_main = cal_active_main & ref_missing;
	wire        set_aux  = cal_active_aux & ref_missing;
	wire [1:0]  settle_need = chop_q ? 2'(sdc_pkg::SETTLE_RESULTS) : 2'h1;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			decimation_factor_reg <= sdc_pkg::SF_RESET;
			eff_sf                <= sdc_pkg::SF_RESET;
			active_sf             <= sdc_pkg::SF_RESET;
			chop_q                <= 1'b0;
			mode_q                <= 1'b0;
			prev_raw              <= 24'h000000;
			settle_cnt            <= 2'h0;
			result                <= 24'h000000;
			result_valid          <= 1'b0;
			result_settled        <= 1'b0;
		end else begin
			if (sf_we)
				decimation_factor_reg <= sf_wdata;
			mode_q       <= mode_reg[sdc_pkg::NOTCH_BIT];
			result_valid <= 1'b0;
			if (reprog) begin
				settle_cnt     <= 2'h0;
				result_settled <= 1'b0;
			end
			if (conv_done) begin
				eff_sf     <= clamped_sf;
				active_sf  <= clamped_sf;
				chop_q     <= cfg.chop_en;
				prev_raw   <= raw_data;
				result     <= ref_missing ? sdc_pkg::CLAMP_CODE : picked;
				result_valid <= 1'b1;
				if (!reprog) begin
					// a chop pair spans two conversions, so the mean is settled on the second
					if (settle_cnt + 2'h1 >= settle_need) begin
						result_settled <= 1'b1;
					end else begin
						settle_cnt <= settle_cnt + 2'h1;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			burnout_en           <= 1'b0;
			use_ext_ref_main     <= 1'b0;
			use_ext_ref_aux      <= 1'b0;
			aux_unipolar         <= 1'b0;
			notch_active         <= 1'b0;
			cal_write_main       <= 1'b0;
			cal_write_aux        <= 1'b0;
			converter_status_reg <= '0;
		end else begin
			burnout_en       <= cfg.burnout_req & (|cfg.input_buffer_bits);
			use_ext_ref_main <= cfg.ext_ref_sel_main;
			use_ext_ref_aux  <= cfg.ext_ref_sel_aux;
			aux_unipolar     <= cfg.aux_polarity_bit;
			// notch forced off below its valid decimation to avoid filter errors
			notch_active     <= mode_reg[sdc_pkg::NOTCH_BIT]
			                    & (active_sf >= sdc_pkg::SF_MIN_NOTCH);
			converter_status_reg.notch_invalid <= mode_reg[sdc_pkg::NOTCH_BIT]
			                    & (active_sf < sdc_pkg::SF_MIN_NOTCH);
			converter_status_reg.no_ext_reference_flag <= ref_missing;
			cal_write_main <= cal_active_main & cal_done & ~ref_missing;
			cal_write_aux  <= cal_active_aux & cal_done & ~ref_missing;
			// set wins over clear so a fault in the clearing cycle survives
			if (set_main)
				converter_status_reg.cal_fault_main <= 1'b1;
			else if (stat_clr)
				converter_status_reg.cal_fault_main <= 1'b0;
			if (set_aux)
				converter_status_reg.cal_fault_aux <= 1'b1;
			else if (stat_clr)
				converter_status_reg.cal_fault_aux <= 1'b0;
		end
	end

	chk_sf_reset_val: assert property (@(posedge clk) $rose(rst_b)
		|-> decimation_factor_reg == 8'h45) else $error("decimation reset value wrong");
	chk_chop_floor_min: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done && cfg.chop_en |=> active_sf >= 8'h0D) else $error("chop floor broken");
	chk_nochop_floor_min: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done && !cfg.chop_en |=> active_sf >= 8'h03) else $error("floor broken");
	chk_sf_write_store: assert property (@(posedge clk) disable iff (!rst_b)
		sf_we |=> decimation_factor_reg == $past(sf_wdata)) else $error("sf write lost");
	chk_burnout_gate: assert property (@(posedge clk) disable iff (!rst_b)
		burnout_en |-> $past(|cfg.input_buffer_bits)) else $error("burnout unbuffered");
	chk_clamp_result: assert property (@(posedge clk) disable iff (!rst_b)
		conv_done && ref_missing |=> result == 24'hFFFFFF) else $error("no clamp");
	chk_cal_block: assert property (@(posedge clk) disable iff (!rst_b)
		ref_missing && cal_active_main |=> !cal_write_main
		&& converter_status_reg.cal_fault_main) else $error("cal not blocked");
	chk_ref_flag: assert property (@(posedge clk) disable iff (!rst_b)
		!ref_sync[0] |=> converter_status_reg.no_ext_reference_flag)
		else $error("ref flag missing");
	chk_notch_valid: assert property (@(posedge clk) disable iff (!rst_b)
		notch_active |-> $past(active_sf) >= 8'h44) else $error("notch below 68");
	chk_polarity_map: assert property (@(posedge clk) disable iff (!rst_b)
		aux_unipolar == $past(cfg.aux_polarity_bit)) else $error("polarity wrong");

	cov_chop_result: cover property (@(posedge clk) disable iff (!rst_b)
		result_valid && chop_q && result_settled);
	cov_ref_lost: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(converter_status_reg.no_ext_reference_flag));
	cov_cal_fault: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(converter_status_reg.cal_fault_aux));
	cov_cal_write: cover property (@(posedge clk) disable iff (!rst_b)
		cal_write_main);
	cov_notch_on: cover property (@(posedge clk) disable iff (!rst_b)
		$rose(notch_active));
endmodule

/* rtl/sdc_pkg.sv */
package sdc_pkg;
	// converter modulator rate is derived from the 100 MHz clock
	localparam int unsigned CLK_HZ          = 100_000_000;
	localparam int unsigned MOD_HZ          = 32_768;
	localparam int unsigned MOD_DIV         = CLK_HZ / MOD_HZ;
	localparam int unsigned SF_W            = 8;
	localparam logic [7:0]  SF_RESET        = 8'h45;
	localparam logic [7:0]  SF_MIN_NOCHOP   = 8'h03;
	localparam logic [7:0]  SF_MIN_CHOP     = 8'h0D;
	localparam logic [7:0]  SF_MAX          = 8'hFF;
	localparam logic [7:0]  SF_MIN_NOTCH    = 8'h44;
	localparam int unsigned NOTCH_BIT       = 6;
	localparam int unsigned DATA_W          = 24;
	// 0.732 ms per decimation step in chop mode: 24 modulator clocks
	localparam real         CHOP_STEP_MS    = 0.732;
	localparam int unsigned CHOP_STEP_MOD   = 24;
	localparam int unsigned NOCHOP_STEP_MOD = 8;
	localparam int unsigned SETTLE_RESULTS  = 2;
	localparam int unsigned STEP_RESULTS    = 3;
	localparam logic [23:0] CLAMP_CODE      = 24'hFFFFFF;

	typedef struct packed {
		logic       chop_en;
		logic [1:0] input_buffer_bits;
		logic       burnout_req;
		logic       ext_ref_sel_main;
		logic       ext_ref_sel_aux;
		logic       aux_polarity_bit;
		logic       notch_sixty_enable;
	} sdc_cfg_t;

	typedef struct packed {
		logic       no_ext_reference_flag;
		logic       cal_fault_main;
		logic       cal_fault_aux;
		logic       notch_invalid;
	} sdc_stat_t;
endpackage

/* rtl/sdc_rate_div.sv */
`timescale 1ns/1ps
// conversion period generator: one pulse per conversion
module sdc_rate_div #(
	parameter int unsigned DIV = sdc_pkg::MOD_DIV
) (
	input  wire logic       clk,
	input  wire logic       rst_b,
	input  wire logic [7:0] eff_sf,
	input  wire logic       chop_en,
	output logic            conv_done
);
	logic [15:0] pre;
	// 255 steps of 24 ticks needs thirteen bits
	logic [12:0] mod_cnt;
	logic [12:0] period;
	wire         mod_tick = (pre == 16'(DIV - 1));

	assign period = chop_en ? 13'(eff_sf) * 13'(sdc_pkg::CHOP_STEP_MOD)
	                        : 13'(eff_sf) * 13'(sdc_pkg::NOCHOP_STEP_MOD);

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pre       <= 16'h0000;
			mod_cnt   <= 13'h0000;
			conv_done <= 1'b0;
		end else begin
			pre       <= mod_tick ? 16'h0000 : pre + 16'h0001;
			conv_done <= 1'b0;
			if (mod_tick) begin
				if (mod_cnt >= period - 13'h0001) begin
					mod_cnt   <= 13'h0000;
					conv_done <= 1'b1;
				end else begin
					mod_cnt <= mod_cnt + 13'h0001;
				end
			end
		end
	end
endmodule

/* rtl/sdc_sync2.sv */
`timescale 1ns/1ps
module sdc_sync2 #(
	parameter int unsigned W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst_b,
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);
	logic [W-1:0] meta;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			meta <= '0;
			dout <= '0;
		end else begin
			meta <= din;
			dout <= meta;
		end
	end
endmodule

/* tb/tb_sdc_ctrl.sv */
`timescale 1ns/1ps
module tb_sdc_ctrl;
	logic               clk = 1'b0;
	logic               rst_b = 1'b0;
	logic               sf_we = 1'b0;
	logic [7:0]         sf_wdata = 8'h00;
	sdc_pkg::sdc_cfg_t  cfg = '0;
	logic [7:0]         mode_reg = 8'h00;
	logic               ref_pos_ok = 1'b1;
	logic               ref_neg_ok = 1'b1;
	logic               ref2_ok = 1'b1;
	logic               cal_active_main = 1'b0;
	logic               cal_active_aux = 1'b0;
	logic               cal_done = 1'b0;
	logic [23:0]        raw_data = 24'h000000;
	logic               stat_clr = 1'b0;
	logic [7:0]         decimation_factor_reg;
	logic [7:0]         active_sf;
	logic [23:0]        result;
	logic               result_valid;
	logic               result_settled;
	logic               burnout_en;
	logic               use_ext_ref_main;
	logic               use_ext_ref_aux;
	logic               aux_unipolar;
	logic               notch_active;
	logic               cal_write_main;
	logic               cal_write_aux;
	sdc_pkg::sdc_stat_t st;
	int                 miscompares = 0;
	int                 checks_done = 0;
	int                 n;
	logic [31:0]        seed = 32'h0000000F;
	logic [23:0]        q[$];
	logic [23:0]        prev;

	// short modulator tick keeps the longest conversion near a thousand cycles
	sdc_ctrl #(.DIV(2)) i_dut (.clk(clk), .rst_b(rst_b), .sf_we(sf_we), .sf_wdata(sf_wdata),
		.cfg(cfg), .mode_reg(mode_reg), .ref_pos_ok(ref_pos_ok), .ref_neg_ok(ref_neg_ok),
		.ref2_ok(ref2_ok), .cal_active_main(cal_active_main), .cal_active_aux(cal_active_aux),
		.cal_done(cal_done), .raw_data(raw_data), .stat_clr(stat_clr),
		.decimation_factor_reg(decimation_factor_reg), .active_sf(active_sf), .result(result),
		.result_valid(result_valid), .result_settled(result_settled), .burnout_en(burnout_en),
		.use_ext_ref_main(use_ext_ref_main), .use_ext_ref_aux(use_ext_ref_aux),
		.aux_unipolar(aux_unipolar), .notch_active(notch_active),
		.cal_write_main(cal_write_main), .cal_write_aux(cal_write_aux),
		.converter_status_reg(st));

	always #5 clk = ~clk;

	function automatic logic [23:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[23:0];
	endfunction

	task automatic finish_test();
		if (miscompares == 0 && checks_done > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		checks_done++;
		if (got !== exp) begin
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
			miscompares++;
		end
	endtask

	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	// counts edges up to and including the next result pulse
	task automatic wait_valid(output int c);
		c = 0;
		do begin
			@(posedge clk);
			c++;
		end while (result_valid !== 1'b1 && c < 4000);
		if (c >= 4000) begin
			miscompares++;
			finish_test();
		end
		#1;
	endtask

	task automatic write_sf(input logic [7:0] v);
		sf_we = 1'b1;
		sf_wdata = v;
		tick(1);
		sf_we = 1'b0;
	endtask

	// first conversion only primes the previous raw value, its result is not judged
	task automatic run_conv(input int k, input bit chop, input bit clamp);
		logic [24:0] s;
		logic [23:0] nr;
		int          c;
		nr = xs();
		raw_data = nr;
		prev = nr;
		wait_valid(c);
		for (int i = 0; i < k; i++) begin
			nr = xs();
			raw_data = nr;
			s = {1'b0, nr} + {1'b0, prev};
			q.push_back(clamp ? sdc_pkg::CLAMP_CODE : (chop ? s[24:1] : nr));
			prev = nr;
			wait_valid(c);
		end
	endtask

	task automatic cal_try(input bit m, output int w);
		cal_active_main = m;
		cal_active_aux = !m;
		tick(1);
		cal_done = 1'b1;
		tick(1);
		cal_done = 1'b0;
		w = 0;
		repeat (4) begin
			@(posedge clk);
			w += ((m ? cal_write_main : cal_write_aux) === 1'b1);
		end
		#1;
		cal_active_main = 1'b0;
		cal_active_aux = 1'b0;
	endtask

	// sampled mid-cycle so the one-cycle result pulse is settled
	always @(negedge clk) begin
		if (result_valid === 1'b1 && q.size() > 0) chk(result, q.pop_front());
	end

	initial begin
		tick(6);
		rst_b = 1'b1;
		chk(24'(decimation_factor_reg), 24'h000045);
		write_sf(8'h03);
		chk(24'(decimation_factor_reg), 24'h000003);
		wait_valid(n);
		wait_valid(n);
		wait_valid(n);
		chk(24'(n), 24'h000030);
		chk(24'(active_sf), 24'h000003);
		run_conv(3, 1'b0, 1'b0);
		cfg.chop_en = 1'b1;
		write_sf(8'h05);
		wait_valid(n);
		wait_valid(n);
		wait_valid(n);
		chk(24'(n), 24'h000270);
		chk(24'(active_sf), 24'h00000D);
		run_conv(4, 1'b1, 1'b0);
		tick(1);
		chk(24'(result_settled), 24'h000001);
		cfg.chop_en = 1'b0;
		write_sf(8'h03);
		ref2_ok = 1'b0;
		tick(5);
		chk(24'(st.no_ext_reference_flag), 24'h000000);
		ref_pos_ok = 1'b0;
		tick(4);
		chk(24'(st.no_ext_reference_flag), 24'h000001);
		run_conv(2, 1'b0, 1'b1);
		cal_try(1'b1, n);
		chk(24'(n), 24'h000000);
		chk(24'(st.cal_fault_main), 24'h000001);
		ref_pos_ok = 1'b1;
		ref_neg_ok = 1'b0;
		tick(4);
		cal_try(1'b0, n);
		chk(24'({n[0], st.cal_fault_aux}), 24'h000001);
		ref_neg_ok = 1'b1;
		ref2_ok = 1'b1;
		stat_clr = 1'b1;
		tick(1);
		stat_clr = 1'b0;
		tick(4);
		chk(24'({st.no_ext_reference_flag, st.cal_fault_main, st.cal_fault_aux}), 24'h0);
		cal_try(1'b1, n);
		chk(24'(n), 24'h000001);
		for (int i = 0; i < 8; i++) begin
			cfg = 8'(xs());
			tick(3);
			chk(24'({burnout_en, use_ext_ref_main, use_ext_ref_aux, aux_unipolar}),
				24'({cfg.burnout_req && cfg.input_buffer_bits != 2'b00, cfg.ext_ref_sel_main,
				cfg.ext_ref_sel_aux, cfg.aux_polarity_bit}));
		end
		cfg.chop_en = 1'b0;
		mode_reg = 8'(xs()) | 8'h40;
		for (int i = 0; i < 2; i++) begin
			write_sf(8'h44 - 8'(i));
			wait_valid(n);
			wait_valid(n);
			tick(1);
			chk(24'({notch_active, st.notch_invalid}), (i == 0) ? 24'h2 : 24'h1);
		end
		finish_test();
	end
endmodule
